/* File: rspc_pkg.sv */
package rspc_pkg;
  // ---------------------------------------------------------------
  // register map (word-aligned byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] RSPC_ADDR_PTR = 8'h00;
  localparam logic [7:0] RSPC_ADDR_TOP_ENTRY_LOW_BYTE = 8'h04;
  localparam logic [7:0] RSPC_ADDR_TOP_ENTRY_HIGH_BYTE = 8'h08;
  localparam logic [7:0] RSPC_ADDR_TOP_ENTRY_UPPER_BYTE = 8'h0C;
  localparam logic [7:0] RSPC_ADDR_PCL = 8'h10;
  localparam logic [7:0] RSPC_ADDR_PC_HIGH_LATCH = 8'h14;
  localparam logic [7:0] RSPC_ADDR_PC_UPPER_LATCH = 8'h18;
  localparam logic [7:0] RSPC_ADDR_CFG = 8'h1C;
  localparam logic [7:0] RSPC_ADDR_PC = 8'h20;
  // ---------------------------------------------------------------
  // field layout and sizes
  // ---------------------------------------------------------------
  localparam int RSPC_FULL_BIT = 7;
  localparam int RSPC_UNF_BIT = 6;
  localparam int RSPC_LVL_W = 5;
  localparam int RSPC_PC_W = 21;
  localparam int RSPC_DEPTH = 31;
  localparam logic [4:0] RSPC_LVL_MAX = 5'h1F;
  localparam logic [4:0] RSPC_LVL_ZERO = 5'h00;
  localparam logic [20:0] RSPC_PC_RESET = 21'h000000;
  localparam logic [20:0] RSPC_PC_STEP = 21'h000002;
  localparam logic RSPC_FAULT_EN_RESET = 1'b1;
  localparam logic [1:0] RSPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSPC_RESP_SLVERR = 2'h2;

  // core operations, one per cycle
  typedef enum logic [3:0] {
    RSPC_OP_NONE = 4'h0,
    RSPC_OP_FETCH = 4'h1,
    RSPC_OP_CALL = 4'h2,
    RSPC_OP_CALL_FAST = 4'h3,
    RSPC_OP_INTR = 4'h4,
    RSPC_OP_RETURN = 4'h5,
    RSPC_OP_RETURN_FAST = 4'h6,
    RSPC_OP_JUMP = 4'h7,
    RSPC_OP_PUSH = 4'h8,
    RSPC_OP_POP = 4'h9
  } rspc_op_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
  } rspc_ctx_t;

  typedef struct packed {
    rspc_op_t op;
    logic [20:0] target;
    rspc_ctx_t ctx;
  } rspc_cmd_t;
endpackage

/* File: rspc_stack_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module rspc_stack_mem
  import rspc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [20:0] wr_data_i,
  input wire logic [4:0] rd_addr_i,
  output logic [20:0] rd_data_o
);
  // index 0 has no storage; entries 1..31
  logic [20:0] mem [1:RSPC_DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i && wr_addr_i != RSPC_LVL_ZERO) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rd_addr_i == RSPC_LVL_ZERO) begin
      rd_data_o <= RSPC_PC_RESET;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule
`default_nettype wire

/* File: rspc_top.sv */
// What this block does
// - pointer 0..31, up on push, down on pop
// - device reset (reset_i) clears the pointer; POR alone does not
// - software reads and writes the pointer
// - full flag set after 31 pushes
// - full flag cleared only by software or POR
// - fault reset on: 31st push stores PC+2, resets
// - fault reset off: pointer sticks at 31
// - pop when empty: underflow set, PC zero on return
// - underflow flag sticky until software or POR
// - underflow resets device when fault reset on
// - pointer register bit layout, reset zero
// - push instruction stores PC at new entry
// - pop instruction only decrements pointer
// - one-deep hidden shadow loaded on interrupt
// - fast return restores shadow
// - every interrupt overwrites the shadow
// - fast call saves into the shadow
// - 21-bit PC, high parts via latches
// - PC bit 0 zero, fetch adds 2
// - calls, gotos, branches ignore the latches
// - PC low write copies latches into PC in a cycle with no core op
// - PC low read copies PC into latches
// - 31 entries of 21 bits, level 0 empty
// - increment then write; read then decrement
// - three top-entry byte registers, read/write
`timescale 1ns/100ps
`default_nettype none
module rspc_top
  import rspc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire rspc_cmd_t cmd_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [20:0] pc_o,
  output rspc_ctx_t ctx_restore_o,
  output logic ctx_restore_valid_o,
  output logic stack_reset_req_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [4:0] level;
  logic stack_full_flag;
  logic stack_underflow_flag;
  logic stack_fault_reset_enable;
  logic [20:0] pc;
  logic [7:0] pc_high_latch;
  logic [4:0] pc_upper_latch;
  rspc_ctx_t shadow;
  logic [20:0] top_entry;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [20:0] mem_wdata;
  logic [4:0] next_level;
  logic [20:0] next_pc;
  logic full_set;
  logic unf_set;
  logic fault;

  // ---------------------------------------------------------------
  // bus slave: write and read handshakes
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic ar_pend;
  logic [7:0] ar_addr;
  logic rd_go;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= RSPC_ADDR_PC) && (a[1:0] == 2'h0);
  endfunction

  assign wr_go = aw_held && w_held && !s_axi_bvalid_o;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RSPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i[7:0];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(aw_addr) ? RSPC_RESP_OKAY
                                          : RSPC_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o)
                         && !s_axi_bvalid_o;
      s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o)
                        && !s_axi_bvalid_o;
    end
  end

  // read: one wait cycle so top_entry from memory is settled
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ar_pend <= 1'b0;
      ar_addr <= 8'h00;
      s_axi_arready_o <= 1'b0;
    end else begin
      s_axi_arready_o <= !ar_pend && !s_axi_rvalid_o
                         && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        ar_pend <= 1'b1;
        ar_addr <= s_axi_araddr_i[7:0];
      end else if (rd_go) begin
        ar_pend <= 1'b0;
      end
    end
  end
  assign rd_go = ar_pend && !s_axi_rvalid_o;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RSPC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= mapped(ar_addr) ? RSPC_RESP_OKAY : RSPC_RESP_SLVERR;
      unique case (ar_addr)
        RSPC_ADDR_PTR: s_axi_rdata_o <= {24'h000000, stack_full_flag,
          stack_underflow_flag, 1'b0, level};
        RSPC_ADDR_TOP_ENTRY_LOW_BYTE: s_axi_rdata_o <= {24'h000000, top_entry[7:0]};
        RSPC_ADDR_TOP_ENTRY_HIGH_BYTE: s_axi_rdata_o <= {24'h000000, top_entry[15:8]};
        RSPC_ADDR_TOP_ENTRY_UPPER_BYTE: s_axi_rdata_o <= {27'h0000000, top_entry[20:16]};
        RSPC_ADDR_PCL: s_axi_rdata_o <= {24'h000000, pc[7:0]};
        RSPC_ADDR_PC_HIGH_LATCH: s_axi_rdata_o <= {24'h000000, pc_high_latch};
        RSPC_ADDR_PC_UPPER_LATCH: s_axi_rdata_o <= {27'h0000000, pc_upper_latch};
        RSPC_ADDR_CFG: s_axi_rdata_o <= {31'h00000000,
          stack_fault_reset_enable};
        RSPC_ADDR_PC: s_axi_rdata_o <= {11'h000, pc};
        default: s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  logic wr_ptr;
  logic wr_top_entry_low_byte;
  logic wr_top_entry_high_byte;
  logic wr_top_entry_upper_byte;
  logic wr_pcl;
  logic rd_pcl;
  assign wr_ptr = wr_go && aw_addr == RSPC_ADDR_PTR && w_strb[0];
  assign wr_top_entry_low_byte = wr_go && aw_addr == RSPC_ADDR_TOP_ENTRY_LOW_BYTE && w_strb[0];
  assign wr_top_entry_high_byte = wr_go && aw_addr == RSPC_ADDR_TOP_ENTRY_HIGH_BYTE && w_strb[0];
  assign wr_top_entry_upper_byte = wr_go && aw_addr == RSPC_ADDR_TOP_ENTRY_UPPER_BYTE && w_strb[0];
  assign wr_pcl = wr_go && aw_addr == RSPC_ADDR_PCL && w_strb[0];
  assign rd_pcl = rd_go && ar_addr == RSPC_ADDR_PCL;

  // ---------------------------------------------------------------
  // stack sequencing
  // ---------------------------------------------------------------
  logic is_push;
  logic is_pop;
  assign is_push = cmd_i.op inside {RSPC_OP_CALL, RSPC_OP_CALL_FAST,
                                    RSPC_OP_INTR, RSPC_OP_PUSH};
  assign is_pop = cmd_i.op inside {RSPC_OP_RETURN, RSPC_OP_RETURN_FAST,
                                   RSPC_OP_POP};

  // top_entry mirrors memory; registered copy tracks writes too
  logic [20:0] mem_rdata;
  always_comb begin
    next_level = level;
    mem_we = 1'b0;
    mem_waddr = level;
    mem_wdata = top_entry;
    full_set = 1'b0;
    unf_set = 1'b0;
    fault = 1'b0;
    if (is_push) begin
      if (level == RSPC_LVL_MAX) begin
        full_set = 1'b1;
      end else begin
        next_level = level + 5'h01;
        mem_we = 1'b1;
        mem_waddr = next_level;
        mem_wdata = pc;
        if (next_level == RSPC_LVL_MAX) begin
          full_set = 1'b1;
          if (stack_fault_reset_enable) begin
            mem_wdata = pc + RSPC_PC_STEP;
            next_level = RSPC_LVL_ZERO;
            fault = 1'b1;
          end
        end
      end
    end else if (is_pop) begin
      if (level == RSPC_LVL_ZERO) begin
        unf_set = 1'b1;
        fault = stack_fault_reset_enable;
      end else begin
        next_level = level - 5'h01;
      end
    end else if (wr_top_entry_low_byte || wr_top_entry_high_byte || wr_top_entry_upper_byte) begin
      mem_we = 1'b1;
      if (wr_top_entry_low_byte) mem_wdata[7:0] = w_data[7:0];
      if (wr_top_entry_high_byte) mem_wdata[15:8] = w_data[7:0];
      if (wr_top_entry_upper_byte) mem_wdata[20:16] = w_data[4:0];
    end
  end

  rspc_stack_mem u_mem (
    .core_clk_i(core_clk_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_addr_i(next_level),
    .rd_data_o(mem_rdata)
  );
  assign top_entry = mem_rdata;

  // pointer: software write lands when no push or pop that cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      level <= RSPC_LVL_ZERO;
    end else if (is_push || is_pop) begin
      level <= next_level;
    end else if (wr_ptr) begin
      level <= w_data[4:0];
    end
  end

  // flags: set wins over software clear; only POR clears otherwise
  always_ff @(posedge core_clk_i) begin
    if (por_i) begin
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else begin
      if (full_set) begin
        stack_full_flag <= 1'b1;
      end else if (wr_ptr && !w_data[RSPC_FULL_BIT]) begin
        stack_full_flag <= 1'b0;
      end
      if (unf_set) begin
        stack_underflow_flag <= 1'b1;
      end else if (wr_ptr && !w_data[RSPC_UNF_BIT]) begin
        stack_underflow_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (por_i) begin
      stack_fault_reset_enable <= RSPC_FAULT_EN_RESET;
    end else if (wr_go && aw_addr == RSPC_ADDR_CFG && w_strb[0]) begin
      stack_fault_reset_enable <= w_data[0];
    end
  end

  // device reset request: one cycle after the faulting op
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stack_reset_req_o <= 1'b0;
    end else begin
      stack_reset_req_o <= fault;
    end
  end

  // ---------------------------------------------------------------
  // program counter and latches
  // ---------------------------------------------------------------
  always_comb begin
    next_pc = pc;
    unique case (cmd_i.op)
      RSPC_OP_FETCH: next_pc = pc + RSPC_PC_STEP;
      RSPC_OP_CALL, RSPC_OP_CALL_FAST, RSPC_OP_JUMP:
        next_pc = cmd_i.target;
      RSPC_OP_RETURN, RSPC_OP_RETURN_FAST:
        next_pc = (level == RSPC_LVL_ZERO) ? RSPC_PC_RESET : top_entry;
      default: next_pc = pc;
    endcase
    if (wr_pcl && cmd_i.op == RSPC_OP_NONE) begin
      next_pc = {pc_upper_latch, pc_high_latch, w_data[7:0]};
    end
    next_pc[0] = 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc <= RSPC_PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_high_latch <= 8'h00;
      pc_upper_latch <= 5'h00;
    end else if (rd_pcl) begin
      pc_high_latch <= pc[15:8];
      pc_upper_latch <= pc[20:16];
    end else if (wr_go && aw_addr == RSPC_ADDR_PC_HIGH_LATCH && w_strb[0]) begin
      pc_high_latch <= w_data[7:0];
    end else if (wr_go && aw_addr == RSPC_ADDR_PC_UPPER_LATCH && w_strb[0]) begin
      pc_upper_latch <= w_data[4:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_o <= RSPC_PC_RESET;
    end else begin
      pc_o <= next_pc;
    end
  end

  // ---------------------------------------------------------------
  // fast register shadow, not visible to software
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      shadow <= '0;
    end else if (cmd_i.op == RSPC_OP_INTR ||
                 cmd_i.op == RSPC_OP_CALL_FAST) begin
      shadow <= cmd_i.ctx;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctx_restore_o <= '0;
      ctx_restore_valid_o <= 1'b0;
    end else begin
      ctx_restore_valid_o <= cmd_i.op == RSPC_OP_RETURN_FAST;
      ctx_restore_o <= shadow;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_push_level_up: assert property (@(posedge core_clk_i) disable iff
    (reset_i) is_push && level < 5'h1E |=> level == $past(level) + 5'h01)
    else $error("push did not raise level");
  a_pop_level_dn: assert property (@(posedge core_clk_i) disable iff
    (reset_i) is_pop && level != 5'h00 |=> level == $past(level) - 5'h01)
    else $error("pop did not lower level");
  a_full_on_31: assert property (@(posedge core_clk_i) disable iff
    (reset_i || por_i) is_push && level == 5'h1E |=> stack_full_flag)
    else $error("full flag missed");
  a_full_sticky: assert property (@(posedge core_clk_i) disable iff
    (por_i) stack_full_flag && !wr_ptr |=> stack_full_flag)
    else $error("full flag dropped");
  a_fault_reset: assert property (@(posedge core_clk_i) disable iff
    (reset_i) is_push && level == 5'h1E && stack_fault_reset_enable
    |=> level == 5'h00 ##0 stack_reset_req_o)
    else $error("fault reset missing");
  a_stick_at_31: assert property (@(posedge core_clk_i) disable iff
    (reset_i) is_push && level == 5'h1F |=> level == 5'h1F)
    else $error("level moved past top");
  a_underflow: assert property (@(posedge core_clk_i) disable iff
    (reset_i || por_i) is_pop && level == 5'h00 && !cmd_i.op[3]
    |=> stack_underflow_flag && pc == 21'h000000 && level == 5'h00)
    else $error("underflow handling wrong");
  a_pc_even: assert property (@(posedge core_clk_i) disable iff
    (reset_i) pc[0] == 1'b0)
    else $error("odd program counter");
  a_fetch_step: assert property (@(posedge core_clk_i) disable iff
    (reset_i) cmd_i.op == RSPC_OP_FETCH |=> pc == $past(pc) + 21'h000002)
    else $error("fetch step wrong");
  a_shadow_back: assert property (@(posedge core_clk_i) disable iff
    (reset_i) cmd_i.op == RSPC_OP_INTR ##1 cmd_i.op == RSPC_OP_RETURN_FAST
    |=> ctx_restore_valid_o && ctx_restore_o == $past(cmd_i.ctx, 2))
    else $error("shadow not restored");
  c_push_full: cover property (@(posedge core_clk_i) full_set);
  c_underflow: cover property (@(posedge core_clk_i) unf_set);
  c_fast_ret: cover property (@(posedge core_clk_i) ctx_restore_valid_o);
  c_pcl_write: cover property (@(posedge core_clk_i) wr_pcl);
endmodule
`default_nettype wire

/* File: rspc_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rspc_core_model
  import rspc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic tb_reset_i,
  input wire logic stack_reset_req_i,
  output rspc_cmd_t cmd_o,
  output logic reset_o,
  output logic [7:0] fault_cnt_o
);
  logic [1:0] hold = 2'h0;
  logic [7:0] cnt = 8'h00;

  initial cmd_o = '0;

  // ---------------------------------------------------------------
  // fault reset: the core turns the request into a device reset
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (stack_reset_req_i) begin
      hold <= 2'h2;
      cnt <= cnt + 8'h01;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
  assign reset_o = tb_reset_i | (hold != 2'h0);
  assign fault_cnt_o = cnt;

  // ---------------------------------------------------------------
  // one decoded op, after an idle gap that varies the pace
  // ---------------------------------------------------------------
  task automatic issue(input rspc_op_t op, input logic [20:0] tgt,
    input rspc_ctx_t ctx, input int gap);
    repeat (gap) @(posedge core_clk_i);
    cmd_o <= {op, tgt, ctx};
    @(posedge core_clk_i);
    cmd_o <= '0;
  endtask
endmodule
`default_nettype wire

/* File: rspc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module rspc_top_tb
  import rspc_pkg::*;
;
  logic clk = 1'b0;
  logic tb_rst = 1'b1;
  logic por = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ctxv, sreq, rst_w;
  logic [1:0] bresp, rresp;
  logic [20:0] pc;
  logic [7:0] fcnt;
  rspc_ctx_t ctxo;
  rspc_cmd_t cmd;
  int error_cnt = 0, cmp_count = 0, seed = 55281, i;
  int m_pc, m_lvl, m_full, m_unf, m_fen, m_lh, m_lu, m_ctx;
  int m_stk[32];

  always #5 clk = ~clk;

  rspc_core_model rspc_core_model_i (.core_clk_i(clk), .tb_reset_i(tb_rst),
    .stack_reset_req_i(sreq), .cmd_o(cmd), .reset_o(rst_w),
    .fault_cnt_o(fcnt));

  rspc_top rspc_top_i (.core_clk_i(clk), .reset_i(rst_w), .por_i(por),
    .cmd_i(cmd), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .pc_o(pc), .ctx_restore_o(ctxo),
    .ctx_restore_valid_o(ctxv), .stack_reset_req_o(sreq));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input int e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic timeout;
    error_cnt++;
    finish_test();
  endtask

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  task automatic mreset(input int p);
    m_pc = 0;
    m_lvl = 0;
    m_lh = 0;
    m_lu = 0;
    m_ctx = 0;
    if (p) begin
      m_full = 0;
      m_unf = 0;
      m_fen = 1;
    end
  endtask

  function automatic int exp_of(input logic [7:0] a);
    case (a)
      RSPC_ADDR_PTR: return (m_full << 7) | (m_unf << 6) | m_lvl;
      RSPC_ADDR_TOP_ENTRY_LOW_BYTE: return m_stk[m_lvl] & 'hFF;
      RSPC_ADDR_TOP_ENTRY_HIGH_BYTE: return (m_stk[m_lvl] >> 8) & 'hFF;
      RSPC_ADDR_TOP_ENTRY_UPPER_BYTE: return m_stk[m_lvl] >> 16;
      RSPC_ADDR_PCL: return m_pc & 'hFF;
      RSPC_ADDR_PC_HIGH_LATCH: return m_lh;
      RSPC_ADDR_PC_UPPER_LATCH: return m_lu;
      RSPC_ADDR_CFG: return m_fen;
      RSPC_ADDR_PC: return m_pc;
      default: return 0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // register bus master; an unmapped place answers with an error
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input int d);
    int n;
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timeout();
    bready <= 1'b0;
    chk("bresp", (a > 8'h20 || a[1:0] != 2'h0) ? 2 : 0, {30'h0, bresp});
    case (a)
      RSPC_ADDR_PTR: begin
        if (!d[7]) m_full = 0;
        if (!d[6]) m_unf = 0;
        m_lvl = d & 'h1F;
      end
      RSPC_ADDR_TOP_ENTRY_LOW_BYTE: m_stk[m_lvl] = (m_stk[m_lvl] & 'h1FFF00) | (d & 'hFF);
      RSPC_ADDR_TOP_ENTRY_HIGH_BYTE: m_stk[m_lvl] = (m_stk[m_lvl] & 'h1F00FF) | (d & 'hFF) << 8;
      RSPC_ADDR_TOP_ENTRY_UPPER_BYTE: m_stk[m_lvl] = (m_stk[m_lvl] & 'hFFFF) | (d & 'h1F) << 16;
      RSPC_ADDR_PCL: m_pc = (m_lu << 16) | (m_lh << 8) | (d & 'hFE);
      RSPC_ADDR_PC_HIGH_LATCH: m_lh = d & 'hFF;
      RSPC_ADDR_PC_UPPER_LATCH: m_lu = d & 'h1F;
      RSPC_ADDR_CFG: m_fen = d & 1;
      default: ;
    endcase
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= {24'h0, a};
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timeout();
    rready <= 1'b0;
    chk("rresp", (a > 8'h20 || a[1:0] != 2'h0) ? 2 : 0, {30'h0, rresp});
    chk("rdata", exp_of(a), rdata);
    if (a == RSPC_ADDR_PCL) begin
      m_lh = (m_pc >> 8) & 'hFF;
      m_lu = m_pc >> 16;
    end
    @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // one core op, model update, pc and pointer comparison
  // ---------------------------------------------------------------
  task automatic core(input rspc_op_t op, input int t = 0, input int c = 0);
    int fault;
    int n;
    logic [7:0] c0;
    fault = 0;
    c0 = fcnt;
    rspc_core_model_i.issue(op, t[20:0], c[23:0], $random(seed) & 3);
    #1;
    case (op)
      RSPC_OP_FETCH: m_pc += 2;
      RSPC_OP_JUMP: m_pc = t;
      RSPC_OP_POP: m_lvl--;
      RSPC_OP_RETURN, RSPC_OP_RETURN_FAST: begin
        if (m_lvl == 0) begin
          m_pc = 0;
          m_unf = 1;
          fault = m_fen;
        end else begin
          m_pc = m_stk[m_lvl];
          m_lvl--;
        end
        if (op == RSPC_OP_RETURN_FAST) begin
          chk("ctx_valid", 1, {31'h0, ctxv});
          chk("ctx", m_ctx, {8'h0, ctxo});
        end
      end
      default: begin
        if (m_lvl < 31) begin
          m_lvl++;
          m_stk[m_lvl] = (m_lvl == 31 && m_fen) ? m_pc + 2 : m_pc;
        end
        if (m_lvl == 31) begin
          m_full = 1;
          fault = m_fen;
        end
        if (op == RSPC_OP_CALL || op == RSPC_OP_CALL_FAST) m_pc = t;
        if (op == RSPC_OP_CALL_FAST || op == RSPC_OP_INTR)
          m_ctx = c & 'hFFFFFF;
      end
    endcase
    if (fault) begin
      n = 0;
      while ((fcnt == c0 || rst_w) && n < 20) begin
        @(posedge clk);
        n++;
      end
      if (n == 20) timeout();
      mreset(0);
      #1;
    end
    chk("pc", m_pc, {11'h0, pc});
    @(posedge clk);
    rd(RSPC_ADDR_PTR);
    if (!fault) chk("fault_req", c0, {24'h0, fcnt});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    mreset(1);
    repeat (5) @(posedge clk);
    tb_rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    rd(RSPC_ADDR_PTR);
    rd(RSPC_ADDR_CFG);
    rd(8'h24);
    wr(8'h22, 'hFF);
    wr(RSPC_ADDR_PC_HIGH_LATCH, 'h5A);
    core(RSPC_OP_JUMP, $random(seed) & 'h1FFFFE);
    repeat (3) core(RSPC_OP_FETCH);
    for (i = 0; i < 4; i++)
      core(RSPC_OP_CALL, $random(seed) & 'h1FFFFE);
    rd(RSPC_ADDR_TOP_ENTRY_LOW_BYTE);
    rd(RSPC_ADDR_TOP_ENTRY_HIGH_BYTE);
    rd(RSPC_ADDR_TOP_ENTRY_UPPER_BYTE);
    wr(RSPC_ADDR_TOP_ENTRY_LOW_BYTE, $random(seed) & 'hFE);
    rd(RSPC_ADDR_TOP_ENTRY_LOW_BYTE);
    core(RSPC_OP_PUSH);
    core(RSPC_OP_POP);
    core(RSPC_OP_INTR, 0, $random(seed));
    core(RSPC_OP_INTR, 0, $random(seed));
    core(RSPC_OP_RETURN_FAST);
    core(RSPC_OP_CALL_FAST, $random(seed) & 'h1FFFFE, $random(seed));
    core(RSPC_OP_RETURN_FAST);
    while (m_lvl > 0) core(RSPC_OP_RETURN);
    wr(RSPC_ADDR_CFG, 0);
    core(RSPC_OP_RETURN);
    wr(RSPC_ADDR_PTR, 'hC3);
    rd(RSPC_ADDR_PTR);
    wr(RSPC_ADDR_PTR, 0);
    rd(RSPC_ADDR_PTR);
    for (i = 0; i < 32; i++) begin
      core(RSPC_OP_FETCH);
      core(RSPC_OP_PUSH);
    end
    rd(RSPC_ADDR_TOP_ENTRY_LOW_BYTE);
    rd(RSPC_ADDR_TOP_ENTRY_HIGH_BYTE);
    wr(RSPC_ADDR_PTR, 0);
    wr(RSPC_ADDR_CFG, 1);
    for (i = 0; i < 31; i++) core(RSPC_OP_PUSH);
    wr(RSPC_ADDR_PTR, 'h9F);
    rd(RSPC_ADDR_TOP_ENTRY_LOW_BYTE);
    rd(RSPC_ADDR_TOP_ENTRY_HIGH_BYTE);
    wr(RSPC_ADDR_PTR, 'h80);
    core(RSPC_OP_RETURN);
    core(RSPC_OP_JUMP, $random(seed) & 'h1FFFFE);
    rd(RSPC_ADDR_PCL);
    rd(RSPC_ADDR_PC_HIGH_LATCH);
    rd(RSPC_ADDR_PC_UPPER_LATCH);
    wr(RSPC_ADDR_PC_HIGH_LATCH, $random(seed) & 'hFF);
    wr(RSPC_ADDR_PC_UPPER_LATCH, $random(seed) & 'h1F);
    wr(RSPC_ADDR_PCL, 'h37);
    rd(RSPC_ADDR_PC);
    tb_rst <= 1'b1;
    por <= 1'b1;
    repeat (2) @(posedge clk);
    tb_rst <= 1'b0;
    por <= 1'b0;
    mreset(1);
    @(posedge clk);
    rd(RSPC_ADDR_PTR);
    rd(RSPC_ADDR_CFG);
    finish_test();
  end
endmodule
`default_nettype wire
